// File: psm_pkg.sv
// Package with register map, field positions, reset values and timing counts.
package psm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PSM_CTRL_OFFS   = 8'h00;
    localparam logic [7:0] PSM_STATUS_OFFS = 8'h04;
    localparam logic [7:0] PSM_WAKE_OFFS   = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PSM_CTRL_TARGET_LSB = 0;
    localparam int PSM_CTRL_PULLDN_BIT = 2;
    localparam int PSM_CTRL_PDCMD_BIT  = 3;
    localparam int PSM_STAT_PEND_BIT   = 2;
    localparam int PSM_STAT_REJ_BIT    = 3;
    localparam int PSM_STAT_CLKSEL_BIT = 4;
    localparam int PSM_WAKE_IRQ_BIT    = 0;
    localparam int PSM_WAKE_WDT_BIT    = 1;
    localparam int PSM_WAKE_LIN_BIT    = 2;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  PSM_TARGET_RST   = 2'h0;
    localparam logic        PSM_PULLDN_RST   = 1'b1;
    localparam logic [31:0] PSM_IRQ_MASK_RST = 32'h0000_0000;
    localparam int PSM_CLK_MHZ     = 100;
    localparam int PSM_FAST_MHZ    = 20;
    localparam int PSM_BASE_FP_KHZ = 4000;
    localparam int PSM_BASE_LP_KHZ = 125;
    localparam int PSM_FAST_DIV    = PSM_FAST_MHZ * 1000 / PSM_BASE_FP_KHZ;
    localparam int PSM_MCU_RST_NS  = 1000;
    localparam int PSM_MCU_RST_CYC = (PSM_MCU_RST_NS * PSM_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Power states and saving target encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSM_FULL_POWER,
        PSM_LOW_POWER,
        PSM_ULTRA_LOW_POWER,
        PSM_OFF
    } psm_state_t;

    localparam logic [1:0] PSM_TGT_LP  = 2'h0;
    localparam logic [1:0] PSM_TGT_ULP = 2'h1;
    localparam logic [1:0] PSM_TGT_OFF = 2'h2;

endpackage

// File: psm_power_state_manager.sv
// Power-state manager with AXI4-Lite register access.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RL1: Reset and every wake enter full power.
// RL2: Full power uses 4MHz base clock.
// RL3: Saving states use 125kHz base clock.
// RL4: Indicator high in full and low power.
// RL5: Both supply rails off in ULTRA_LOW_POWER_STATE/off.
// RL6: Digital I/Os inactive in ULTRA_LOW_POWER_STATE/off.
// RL7: Pull-downs on after reset, then software.
// RL8: Low power wakes on irq or watchdog.
// RL9: Low power wake keeps microcontroller running.
// RL10: Reject power-down while enabled irq active.
// RL11: Software sets wake sources, target, command.
// RL12: Accepted command takes effect on CS rise.
// RL13: Master should keep CS low after command.
// RL14: ULTRA_LOW_POWER_STATE is low power plus MCU unpowered.
// RL15: Wake from ULTRA_LOW_POWER_STATE/off resets the microcontroller.
// RL16: Off stops oscillators, no measurements.
// RL17: Off left only by enabled LIN wakeup; the code has no LIN enable bit, so any lin_wakeup leaves off.
// RL18: Unpowered MCU disables outputs in ULTRA_LOW_POWER_STATE/off.
// RL19: Master raises CS after power writes.
// RL20: CS rise without command only ends transfer.
module psm_power_state_manager #(
    parameter int IRQ_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Link and wake sources
    input  wire logic                 chip_select_n,
    input  wire logic [IRQ_WIDTH-1:0] irq_active,
    input  wire logic                 watchdog_reset,
    input  wire logic                 lin_wakeup,
    // Power outputs
    output logic                      power_state_indicator,
    output logic                      io_supply_rail,
    output logic                      core_supply_rail,
    output logic                      io_enable,
    output logic                      pulldown_enable,
    output logic                      mcu_reset_n,
    output logic                      base_clock_select,
    output logic                      base_clock_tick,
    output logic                      fast_osc_enable,
    output logic                      lp_osc_enable,
    output logic [1:0]                power_state
);

    // ------------------------------------------------------------------
    // Register and state storage
    // ------------------------------------------------------------------
    psm_pkg::psm_state_t state;
    logic [1:0]           target_state_select;
    logic [IRQ_WIDTH-1:0] irq_wake_enable;
    logic                 cmd_pending;
    logic                 cmd_rejected;
    logic                 cs_prev;
    logic [2:0]           wake_cause;
    logic [7:0]           rst_cnt;
    logic [9:0]           div_cnt;
    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire logic       do_write   = aw_held && w_held && !s_axi_bvalid;
    wire logic       wr_ctrl    = do_write
                                  && aw_addr == psm_pkg::PSM_CTRL_OFFS;
    wire logic       wr_wake    = do_write
                                  && aw_addr == psm_pkg::PSM_WAKE_OFFS;
    wire logic       wr_known   = wr_ctrl || wr_wake;
    wire logic       cmd_write  = wr_ctrl && w_strb[0]
                                  && w_data[psm_pkg::PSM_CTRL_PDCMD_BIT];
    wire logic       wake_block = |(irq_active & irq_wake_enable);
    wire logic       cs_rise    = chip_select_n && !cs_prev;
    wire logic       in_full    = state == psm_pkg::PSM_FULL_POWER;
    wire logic       saving     = !in_full;
    wire logic       unpowered  = state == psm_pkg::PSM_ULTRA_LOW_POWER
                                  || state == psm_pkg::PSM_OFF;
    wire logic       do_read    = s_axi_arvalid && !s_axi_rvalid;
    wire logic [9:0] div_top    = saving
        ? 10'(psm_pkg::PSM_CLK_MHZ * 1000 / psm_pkg::PSM_BASE_LP_KHZ - 1)
        : 10'(psm_pkg::PSM_CLK_MHZ / psm_pkg::PSM_FAST_MHZ
              * psm_pkg::PSM_FAST_DIV - 1);
    // RL8 RL17 wake decision
    wire logic wake_now =
        (state == psm_pkg::PSM_LOW_POWER
            && (wake_block || watchdog_reset))
        || (state == psm_pkg::PSM_ULTRA_LOW_POWER && wake_block)
        || (state == psm_pkg::PSM_OFF && lin_wakeup);

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            psm_pkg::PSM_CTRL_OFFS: begin
                rd_word[1:0] = target_state_select;
                rd_word[psm_pkg::PSM_CTRL_PULLDN_BIT] = pulldown_enable;
            end
            psm_pkg::PSM_STATUS_OFFS: begin
                rd_word[1:0] = state;
                rd_word[psm_pkg::PSM_STAT_PEND_BIT]   = cmd_pending;
                rd_word[psm_pkg::PSM_STAT_REJ_BIT]    = cmd_rejected;
                rd_word[psm_pkg::PSM_STAT_CLKSEL_BIT] = base_clock_select;
                rd_word[10:8] = wake_cause;
            end
            psm_pkg::PSM_WAKE_OFFS: begin
                rd_word[IRQ_WIDTH-1:0] = irq_wake_enable;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    wire logic rd_known = s_axi_araddr == psm_pkg::PSM_CTRL_OFFS
                          || s_axi_araddr == psm_pkg::PSM_STATUS_OFFS
                          || s_axi_araddr == psm_pkg::PSM_WAKE_OFFS;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
            s_axi_arready <= do_read && !s_axi_arready;
            if (do_read && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_state_select <= psm_pkg::PSM_TARGET_RST;
            // RL7 pull-downs on
            pulldown_enable     <= psm_pkg::PSM_PULLDN_RST;
            irq_wake_enable     <= IRQ_WIDTH'(psm_pkg::PSM_IRQ_MASK_RST);
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                target_state_select <= w_data[1:0];
                // RL7 software pull-down control
                pulldown_enable <= w_data[psm_pkg::PSM_CTRL_PULLDN_BIT];
            end
            if (wr_wake && w_strb[0]) begin
                irq_wake_enable <= w_data[IRQ_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Power-state sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // RL1 reset enters full power
            state        <= psm_pkg::PSM_FULL_POWER;
            cmd_pending  <= 1'b0;
            cmd_rejected <= 1'b0;
            cs_prev      <= 1'b1;
            wake_cause   <= 3'b000;
        end else begin
            cs_prev <= chip_select_n;
            case (state)
                psm_pkg::PSM_FULL_POWER: begin
                    // RL12 RL20 act on CS rise only
                    if (cs_rise && cmd_pending) begin
                        cmd_pending <= 1'b0;
                        case (target_state_select)
                            psm_pkg::PSM_TGT_LP:
                                state <= psm_pkg::PSM_LOW_POWER;
                            psm_pkg::PSM_TGT_ULP:
                                state <= psm_pkg::PSM_ULTRA_LOW_POWER;
                            psm_pkg::PSM_TGT_OFF:
                                state <= psm_pkg::PSM_OFF;
                            default:
                                state <= psm_pkg::PSM_FULL_POWER;
                        endcase
                    end
                    // RL10 reject while enabled irq active
                    if (cmd_write) begin
                        cmd_pending  <= !wake_block;
                        cmd_rejected <= wake_block;
                    end
                end
                psm_pkg::PSM_LOW_POWER,
                psm_pkg::PSM_ULTRA_LOW_POWER,
                psm_pkg::PSM_OFF: begin
                    cmd_pending <= 1'b0;
                    // RL1 wake returns to full power
                    if (wake_now) begin
                        state <= psm_pkg::PSM_FULL_POWER;
                        wake_cause <= {lin_wakeup, watchdog_reset,
                                       wake_block};
                    end
                end
                default: begin
                    state <= psm_pkg::PSM_FULL_POWER;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Microcontroller reset and base clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt <= 8'(psm_pkg::PSM_MCU_RST_CYC);
            div_cnt <= 10'h000;
        end else begin
            // RL15 RL9 reset only after unpowered states
            if (unpowered) begin
                rst_cnt <= 8'(psm_pkg::PSM_MCU_RST_CYC);
            end else if (rst_cnt != 8'h00) begin
                rst_cnt <= rst_cnt - 8'h01;
            end
            // RL16 no base clock when off
            if (state == psm_pkg::PSM_OFF || div_cnt >= div_top) begin
                div_cnt <= 10'h000;
            end else begin
                div_cnt <= div_cnt + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered power outputs
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_state_indicator <= 1'b1;
            io_supply_rail        <= 1'b1;
            core_supply_rail      <= 1'b1;
            io_enable             <= 1'b1;
            mcu_reset_n           <= 1'b0;
            base_clock_select     <= 1'b0;
            base_clock_tick       <= 1'b0;
            fast_osc_enable       <= 1'b1;
            lp_osc_enable         <= 1'b1;
            power_state           <= 2'b00;
        end else begin
            // RL4 indicator
            power_state_indicator <= !unpowered;
            // RL5 RL14 rails off
            io_supply_rail   <= !unpowered;
            core_supply_rail <= !unpowered;
            // RL6 I/Os off
            io_enable   <= !unpowered;
            mcu_reset_n <= !unpowered && rst_cnt == 8'h00;
            // RL2 RL3 base clock choice
            base_clock_select <= saving;
            base_clock_tick   <= state != psm_pkg::PSM_OFF
                                 && div_cnt == div_top;
            // RL16 oscillators stopped
            fast_osc_enable <= in_full;
            lp_osc_enable   <= state != psm_pkg::PSM_OFF;
            power_state     <= state;
        end
    end

endmodule

`default_nettype wire

// File: psm_checker_sva.sv
// Concurrent assertions on the power-state manager pins.
`timescale 1ns/100ps
`default_nettype none
module psm_checker (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Requests and wake sources
    input wire logic       chip_select_n,
    input wire logic       watchdog_reset,
    input wire logic       lin_wakeup,
    // Power outputs
    input wire logic       power_state_indicator,
    input wire logic       io_supply_rail,
    input wire logic       core_supply_rail,
    input wire logic       io_enable,
    input wire logic       mcu_reset_n,
    input wire logic       base_clock_select,
    input wire logic       base_clock_tick,
    input wire logic       fast_osc_enable,
    input wire logic       lp_osc_enable,
    input wire logic [1:0] power_state
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    indicator_a: assert property (
        power_state_indicator == (power_state < 2'h2))
        else $error("indicator does not match power state");
    rails_off_a: assert property (
        {io_supply_rail, core_supply_rail} == {2{power_state < 2'h2}})
        else $error("supply rails do not match power state");
    io_off_a: assert property (
        io_enable == (power_state < 2'h2))
        else $error("digital I/O power does not match state");
    clock_base_a: assert property (
        power_state != 2'h3 |->
            base_clock_select == (power_state != 2'h0))
        else $error("base clock select wrong for state");
    off_osc_a: assert property (
        power_state == 2'h3 |->
            !fast_osc_enable && !lp_osc_enable && !base_clock_tick)
        else $error("oscillator running in off state");
    cs_edge_a: assert property (
        $past(power_state) == 2'h0 && power_state != 2'h0 |->
            $past(chip_select_n, 2) && !$past(chip_select_n, 3))
        else $error("saving state entered without chip select high");
    lp_wake_a: assert property (
        power_state == 2'h1 && watchdog_reset |-> ##2 power_state == 2'h0)
        else $error("low power did not wake on watchdog");
    off_hold_a: assert property (
        power_state == 2'h3 && !$past(lin_wakeup) |=> power_state == 2'h3)
        else $error("off state left without LIN wakeup");
    lp_keep_a: assert property (
        power_state == 2'h1 ##1 power_state == 2'h0 |-> mcu_reset_n [*3])
        else $error("microcontroller reset on low power wake");
    deep_reset_a: assert property (
        $past(power_state) >= 2'h2 && power_state == 2'h0
            |=> !mcu_reset_n [*8])
        else $error("microcontroller not reset after deep wake");

    cover property (power_state == 2'h1);
    cover property (power_state == 2'h2);
    cover property (power_state == 2'h3);
endmodule

bind psm_power_state_manager psm_checker psm_checker_i (
    .aclk, .aresetn, .chip_select_n, .watchdog_reset, .lin_wakeup,
    .power_state_indicator, .io_supply_rail, .core_supply_rail,
    .io_enable, .mcu_reset_n, .base_clock_select, .base_clock_tick,
    .fast_osc_enable, .lp_osc_enable, .power_state);
`default_nettype wire

// File: psm_mcu_model.sv
// Microcontroller model that owns the chip-select line.
`timescale 1ns/100ps
`default_nettype none
module psm_mcu_model (
    // Clock and reset
    input wire logic  aclk,
    input wire logic  aresetn,
    // Bench request and device outputs
    input wire logic  end_req,
    input wire logic  io_supply_rail,
    input wire logic  pulldown_enable,
    // Line to the device
    output logic      chip_select_n
);
    logic [5:0] hi_cnt;
    logic       tgl;

    // line held low except to end a power write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt <= 6'h00;
            tgl    <= 1'b0;
        end else begin
            tgl    <= ~tgl;
            hi_cnt <= end_req ? 6'h1e : hi_cnt - {5'h00, hi_cnt != 6'h00};
        end
    end
    // unpowered outputs released, so the line floats or is pulled
    assign chip_select_n = io_supply_rail ? (hi_cnt != 6'h00)
                         : (pulldown_enable ? 1'b0 : tgl);
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the power-state manager.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0, end_req = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0]  irq_active = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, watchdog_reset = 1'b0;
    logic        lin_wakeup = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, chip_select_n, power_state_indicator;
    logic        io_supply_rail, core_supply_rail, io_enable;
    logic        pulldown_enable, mcu_reset_n, base_clock_select;
    logic        fast_osc_enable, lp_osc_enable, base_clock_tick;
    logic [1:0]  s_axi_bresp, s_axi_rresp, power_state, last_rresp;
    int          fail_count = 0, comparisons = 0;

    always #5 aclk = ~aclk;

    psm_power_state_manager #(.IRQ_WIDTH(8)) psm_power_state_manager_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .chip_select_n, .irq_active,
        .watchdog_reset, .lin_wakeup, .power_state_indicator,
        .io_supply_rail, .core_supply_rail, .io_enable, .pulldown_enable,
        .mcu_reset_n, .base_clock_select, .base_clock_tick,
        .fast_osc_enable, .lp_osc_enable, .power_state);

    psm_mcu_model psm_mcu_model_i (.aclk, .aresetn, .end_req,
        .io_supply_rail, .pulldown_enable, .chip_select_n);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        last_rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic pulse_cs();
        @(posedge aclk);
        end_req <= 1'b1;
        @(posedge aclk);
        end_req <= 1'b0;
    endtask

    task automatic wait_st(input logic [1:0] s, input string msg);
        int n;
        n = 0;
        while (power_state !== s && n < 60) begin
            @(negedge aclk);
            n++;
        end
        chk(power_state, s, msg);
    endtask

    task automatic wait_rst();
        int n;
        n = 0;
        while (mcu_reset_n !== 1'b1 && n < 150) begin
            @(negedge aclk);
            n++;
        end
        chk(mcu_reset_n, 1'b1, "mcu reset release");
    endtask

    // Measures the gap between two base clock ticks against the rate.
    task automatic tick_gap(input int khz, input string msg);
        int n;
        n = 0;
        while (base_clock_tick !== 1'b1 && n < 2000) begin
            @(negedge aclk);
            n++;
        end
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (base_clock_tick !== 1'b1 && n < 2000);
        chk(n, psm_pkg::PSM_CLK_MHZ * 1000 / khz, msg);
    endtask

    initial begin
        #400_000;
        fail_count++;
        final_report();
    end

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic        pd;
        int          k;
        void'($urandom(32'h72f4));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(pulldown_enable, 1'b1, "pulldown after reset");
        chk(power_state, 2'h0, "state after reset");
        wait_rst();
        axr(8'h00, d);
        chk(d, 32'h0000_0004, "control reset value");
        chk(last_rresp, 2'h0, "control read response");
        axr(8'h0c, d);
        chk(last_rresp, 2'h2, "unmapped read response");
        tick_gap(psm_pkg::PSM_BASE_FP_KHZ, "fast tick period");
        axw(8'h04, 32'h0000_0000, r);
        chk(r, 2'h2, "status write response");
        axw(8'h0c, 32'h0000_0000, r);
        chk(r, 2'h2, "unmapped write response");
        pulse_cs();
        repeat (35) @(negedge aclk);
        chk(power_state, 2'h0, "edge without command");
        k = $urandom_range(7, 0);
        axw(8'h08, 32'h0000_0001 << k, r);
        irq_active <= 8'h01 << k;
        axw(8'h00, 32'h0000_000c, r);
        pulse_cs();
        repeat (35) @(negedge aclk);
        chk(power_state, 2'h0, "command with active irq");
        axr(8'h04, d);
        chk(d[3], 1'b1, "reject flag");
        irq_active <= 8'h00;
        $display("test setup done");
        for (int t = 0; t < 3; t++) begin
            k  = $urandom_range(7, 0);
            pd = 1'($urandom_range(1, 0));
            axw(8'h08, 32'h0000_0001 << k, r);
            axw(8'h00, {28'h000_0000, 1'b1, pd, 2'(t)}, r);
            chk(pulldown_enable, pd, "pulldown write");
            pulse_cs();
            wait_st(2'(t + 1), "saving state entry");
            repeat (2) @(negedge aclk);
            chk(power_state_indicator, t == 0, "indicator");
            chk(core_supply_rail, t == 0, "core rail");
            chk(io_enable, t == 0, "io power");
            if (t < 2) chk(base_clock_select, 1'b1, "slow base");
            if (t < 2) tick_gap(psm_pkg::PSM_BASE_LP_KHZ, "slow tick");
            else chk(fast_osc_enable | lp_osc_enable, 1'b0, "osc off");
            @(posedge aclk);
            if (t == 0) watchdog_reset <= 1'b1;
            else irq_active <= 8'h01 << k;
            if (t == 2) begin
                repeat (20) @(negedge aclk);
                chk(power_state, 2'h3, "off holds on irq");
                @(posedge aclk);
                lin_wakeup <= 1'b1;
            end
            wait_st(2'h0, "wake to full power");
            @(posedge aclk);
            {watchdog_reset, lin_wakeup, irq_active} <= 10'h000;
            @(negedge aclk);
            chk(mcu_reset_n, t == 0, "mcu reset on wake");
            chk(base_clock_select, 1'b0, "fast base");
            wait_rst();
            $display("test saving state %0d done", t);
        end
        final_report();
    end
endmodule
`default_nettype wire
